// File: design/pie_pkg.sv
// shared constants and types of the image inversion engine
package pie_pkg;
    // ======================================
    // frame geometry
    localparam int FRAME_WIDTH_PX = 320; // pixels per line
    localparam int FRAME_HEIGHT_LINES = 240; // lines per frame
    localparam int FRAME_BYTES_PER_PX = 3; // bytes per pixel
    localparam int FRAME_BYTE_COUNT = FRAME_WIDTH_PX * FRAME_HEIGHT_LINES * FRAME_BYTES_PER_PX;
    // ======================================
    // local address map
    localparam int ADDR_W = 18; // local dma byte address width
    localparam int DATA_W = 32; // dma and register word width
    localparam int CSR_ADDR_W = 8; // register window offset width
    localparam logic [ADDR_W-1:0] FRAME_BASE = 18'h00000; // frame buffer base
    localparam logic [CSR_ADDR_W-1:0] CSR_OFS = 8'h10; // control/status register
    localparam int CSR_BUSY_POS = 0; // busy flag position
    localparam logic [DATA_W-1:0] CSR_RESET = 32'h00000000; // reads idle after reset
    localparam int FIFO_DEPTH_DEF = 16; // write buffer depth
    // ======================================
    // carriers and states
    typedef struct packed {
        logic [ADDR_W-1:0] addr; // byte address
        logic [DATA_W-1:0] data; // payload word
    } pie_dma_wr_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, // waiting for a start write
        ST_DRAIN = 2'b01, // flushing buffered dma writes
        ST_WALK = 2'b10 // inverting the frame word by word
    } pie_state_t;
endpackage

// File: design/pie_invert_engine.sv
// image inversion engine: frame buffer, write buffer, control/status register
`timescale 1ns/1ps

// ======================================
// write buffer between the dma channel and the frame memory
module pie_fifo import pie_pkg::*; #(
    parameter int WIDTH = 50,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth, so refuse others at elaboration
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] slot [DEPTH]; // storage flops
    logic [PW:0] wrPtr_q, wrPtr_d; // extra bit tells full from empty
    logic [PW:0] rdPtr_q, rdPtr_d;
    logic push, pop;

    // full and empty straight from the pointers, so ready is honest
    always_comb begin
        inReady = (wrPtr_q[PW-1:0] != rdPtr_q[PW-1:0]) || (wrPtr_q[PW] == rdPtr_q[PW]);
        outValid = (wrPtr_q != rdPtr_q);
        outData = slot[rdPtr_q[PW-1:0]];
        push = inValid && inReady;
        pop = outValid && outReady;
        wrPtr_d = wrPtr_q + (PW+1)'(push);
        rdPtr_d = rdPtr_q + (PW+1)'(pop);
    end

    // pointer registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    // storage carries no reset; only written slots are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            slot[wrPtr_q[PW-1:0]] <= inData;
        end
    end
endmodule

// ======================================
// top of the engine, facing the pcie core's register and dma channels
module pie_invert_engine import pie_pkg::*; #(
    parameter int WIDTH_PX = FRAME_WIDTH_PX,
    parameter int HEIGHT_LINES = FRAME_HEIGHT_LINES,
    parameter int BYTES_PX = FRAME_BYTES_PER_PX,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
    parameter logic [15:0] MAKER_ID_CODE = 16'h5A5A, // arbitrary value
    parameter logic [15:0] PART_ID_CODE = 16'h0C3C // arbitrary value
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register channel
    input wire logic csrWrite,
    input wire logic csrRead,
    input wire logic [CSR_ADDR_W-1:0] csrAddr,
    input wire logic [DATA_W-1:0] csrWdata,
    output logic csrRdValid,
    output logic [DATA_W-1:0] csrRdData,
    // dma write channel
    input wire logic dmaWrValid,
    output logic dmaWrReady,
    input wire logic [ADDR_W-1:0] dmaWrAddr,
    input wire logic [DATA_W-1:0] dmaWrData,
    // dma read channel
    input wire logic dmaRdReq,
    input wire logic [ADDR_W-1:0] dmaRdAddr,
    output logic dmaRdValid,
    output logic [DATA_W-1:0] dmaRdData,
    // identity and status
    output logic [15:0] makerIdCode,
    output logic [15:0] partIdCode,
    output logic engineBusy
);
    localparam int BYTES = WIDTH_PX * HEIGHT_LINES * BYTES_PX;
    localparam int WORDS = BYTES / 4;
    localparam int IDX_W = $clog2(WORDS);
    localparam int LAST = WORDS - 1;
    localparam int FW = ADDR_W + DATA_W;

    // the walk moves whole words, so refuse frames that are not whole words
    if (BYTES % 4 != 0 || WORDS < 2 || IDX_W > ADDR_W - 2) begin : g_frame_check
        $error("frame size must be whole words and fit the address");
    end

    // ======================================
    // declarations
    logic [DATA_W-1:0] frameMem [WORDS]; // the frame buffer itself
    pie_state_t state_q, state_d; // engine state
    logic [IDX_W-1:0] idx_q, idx_d; // walk position
    logic csrRdValid_q, csrRdValid_d;
    logic [DATA_W-1:0] csrRdData_q, csrRdData_d;
    logic dmaRdValid_q, dmaRdValid_d;
    logic [DATA_W-1:0] dmaRdData_q, dmaRdData_d;
    pie_dma_wr_t fifoIn, fifoOut; // buffered dma write
    logic fifoOutValid, drainReady;
    logic memWe; // one memory write port
    logic [IDX_W-1:0] memIdx;
    logic [DATA_W-1:0] memData;
    logic csrHit, startHit, wrInRange, rdInRange;
    logic [ADDR_W-3:0] wrWord, rdWord;

    // ======================================
    // dma writes pass the buffer; ready stalls the core while it is full
    assign fifoIn = '{addr: dmaWrAddr, data: dmaWrData};

    pie_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wrFifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .inValid(dmaWrValid),
        .inReady(dmaWrReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(drainReady),
        .outData(fifoOut)
    );

    // ======================================
    // address decode
    always_comb begin
        csrHit = (csrAddr == CSR_OFS);
        startHit = csrWrite && csrHit; // data value ignored
        wrWord = fifoOut.addr[ADDR_W-1:2] - FRAME_BASE[ADDR_W-1:2];
        rdWord = dmaRdAddr[ADDR_W-1:2] - FRAME_BASE[ADDR_W-1:2];
        wrInRange = (int'(wrWord) < WORDS);
        rdInRange = (int'(rdWord) < WORDS);
    end

    // ======================================
    // engine: next state, walk index and the single memory write
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        drainReady = 1'b0;
        memWe = 1'b0;
        memIdx = wrWord[IDX_W-1:0];
        memData = fifoOut.data;
        case (state_q)
            ST_IDLE: begin
                // host dma writes land in the frame buffer
                drainReady = 1'b1;
                memWe = fifoOutValid && wrInRange;
                if (startHit) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // writes taken before the start must land before the walk
                drainReady = 1'b1;
                memWe = fifoOutValid && wrInRange;
                if (!fifoOutValid) begin
                    state_d = ST_WALK;
                    idx_d = '0;
                end
            end
            ST_WALK: begin
                // complement in place, one word per cycle
                memWe = 1'b1;
                memIdx = idx_q;
                memData = ~frameMem[idx_q];
                if (int'(idx_q) == LAST) begin
                    state_d = ST_IDLE;
                end else begin
                    idx_d = idx_q + IDX_W'(1);
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // engine registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end

    // frame memory; no reset, contents are whatever the host loaded
    always_ff @(posedge core_clk) begin
        if (memWe) begin
            frameMem[memIdx] <= memData;
        end
    end

    // ======================================
    // read answers, one cycle after the request
    always_comb begin
        csrRdValid_d = csrRead;
        csrRdData_d = '0; // unmapped offsets read zero
        if (csrRead && csrHit) begin
            // nonzero while busy, zero once done
            csrRdData_d = CSR_RESET;
            csrRdData_d[CSR_BUSY_POS] = (state_q != ST_IDLE);
        end
        dmaRdValid_d = dmaRdReq;
        dmaRdData_d = '0; // out of frame reads zero
        if (dmaRdReq && rdInRange) begin
            dmaRdData_d = frameMem[rdWord[IDX_W-1:0]];
        end
    end

    // answer registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            csrRdValid_q <= 1'b0;
            csrRdData_q <= CSR_RESET;
            dmaRdValid_q <= 1'b0;
            dmaRdData_q <= '0;
        end else begin
            csrRdValid_q <= csrRdValid_d;
            csrRdData_q <= csrRdData_d;
            dmaRdValid_q <= dmaRdValid_d;
            dmaRdData_q <= dmaRdData_d;
        end
    end

    // ======================================
    // outputs
    assign csrRdValid = csrRdValid_q;
    assign csrRdData = csrRdData_q;
    assign dmaRdValid = dmaRdValid_q;
    assign dmaRdData = dmaRdData_q;
    assign makerIdCode = MAKER_ID_CODE;
    assign partIdCode = PART_ID_CODE;
    assign engineBusy = (state_q != ST_IDLE);

    // ======================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_start;
        state_q == ST_IDLE && csrWrite && csrAddr == CSR_OFS;
    endsequence
    sequence s_last;
        state_q == ST_WALK && int'(idx_q) == LAST;
    endsequence

    a_start_any_value: assert property (s_start |=> state_q == ST_DRAIN)
        else $error("start write did not start the engine");
    a_busy_reads_one: assert property (
        csrRead && csrHit && state_q != ST_IDLE |=> csrRdValid && csrRdData == 32'h00000001)
        else $error("busy engine did not read nonzero");
    a_done_reads_zero: assert property (
        s_last ##1 (csrRead && csrHit) |=> csrRdValid && csrRdData == 32'h00000000)
        else $error("finished engine did not read zero");
    a_walk_inverts: assert property (
        state_q == ST_WALK |=> frameMem[$past(idx_q)] == ~$past(frameMem[idx_q]))
        else $error("walk did not write the complement");
    a_walk_steps: assert property (
        state_q == ST_WALK && int'(idx_q) != LAST |=> state_q == ST_WALK
        && idx_q == $past(idx_q) + IDX_W'(1))
        else $error("walk skipped or stalled");
    a_walk_ends: assert property (s_last |=> state_q == ST_IDLE)
        else $error("walk did not end at the last frame word");
    a_base_zero: assert property (
        drainReady && fifoOutValid && fifoOut.addr == FRAME_BASE |-> memWe && memIdx == '0)
        else $error("base address did not map to word zero");
    a_dma_read_answer: assert property (
        dmaRdReq && rdInRange && !memWe |=> dmaRdValid
        && dmaRdData == frameMem[$past(rdWord[IDX_W-1:0])])
        else $error("dma read returned wrong data");
    a_id_fixed: assert property (
        makerIdCode == MAKER_ID_CODE && partIdCode == PART_ID_CODE)
        else $error("identity codes changed");
endmodule

// File: testbench/pie_host_model.sv
// host-side partner driving the register and dma channels of the engine
`timescale 1ns/1ps
module pie_host_model import pie_pkg::*; (
    // clock
    input wire logic core_clk,
    // register channel
    output logic csrWrite,
    output logic csrRead,
    output logic [CSR_ADDR_W-1:0] csrAddr,
    output logic [DATA_W-1:0] csrWdata,
    input wire logic csrRdValid,
    input wire logic [DATA_W-1:0] csrRdData,
    // dma channels
    output logic dmaWrValid,
    input wire logic dmaWrReady,
    output logic [ADDR_W-1:0] dmaWrAddr,
    output logic [DATA_W-1:0] dmaWrData,
    output logic dmaRdReq,
    output logic [ADDR_W-1:0] dmaRdAddr,
    input wire logic dmaRdValid,
    input wire logic [DATA_W-1:0] dmaRdData
);
    // ======================================
    // idle levels at time zero
    initial begin
        {csrWrite, csrRead, dmaWrValid, dmaRdReq} = 4'h0;
        {csrAddr, csrWdata, dmaWrAddr, dmaWrData, dmaRdAddr} = '0;
    end
    // one-cycle write strobe; released lines are scrambled, not left stale
    task automatic csrWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        csrWrite <= 1'b1;
        csrAddr <= a;
        csrWdata <= d;
        @(posedge core_clk);
        csrWrite <= 1'b0;
        csrAddr <= ~a;
        csrWdata <= ~d;
    endtask
    // read strobe, then a short bounded wait for the answer
    task automatic csrRd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(posedge core_clk);
        csrRead <= 1'b1;
        csrAddr <= a;
        @(posedge core_clk);
        csrRead <= 1'b0;
        csrAddr <= ~a;
        ok = 1'b0;
        d = '0;
        for (int i = 0; i < 3 && !ok; i++) begin
            #1;
            if (csrRdValid === 1'b1) begin
                ok = 1'b1;
                d = csrRdData;
            end else @(posedge core_clk);
        end
    endtask
    // offer one word; ready is sampled mid-cycle so the edge never races it
    task automatic dmaWr(input logic [17:0] a, input logic [31:0] d, input int bound,
                         output logic ok);
        logic r;
        @(posedge core_clk);
        dmaWrValid <= 1'b1;
        dmaWrAddr <= a;
        dmaWrData <= d;
        ok = 1'b0;
        for (int i = 0; i < bound && !ok; i++) begin
            @(negedge core_clk) r = dmaWrReady;
            @(posedge core_clk) ok = r;
        end
        dmaWrValid <= 1'b0;
        dmaWrAddr <= ~a;
        dmaWrData <= ~d;
    endtask
    // fetch one word; used only while the engine is idle
    task automatic dmaRd(input logic [17:0] a, output logic [31:0] d, output logic ok);
        @(posedge core_clk);
        dmaRdReq <= 1'b1;
        dmaRdAddr <= a;
        @(posedge core_clk);
        dmaRdReq <= 1'b0;
        dmaRdAddr <= ~a;
        ok = 1'b0;
        d = '0;
        for (int i = 0; i < 3 && !ok; i++) begin
            #1;
            if (dmaRdValid === 1'b1) begin
                ok = 1'b1;
                d = dmaRdData;
            end else @(posedge core_clk);
        end
    endtask
    // poll the status word until it reads zero, bounded
    task automatic pollIdle(output logic ok);
        logic [31:0] v;
        logic got;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            csrRd(CSR_OFS, v, got);
            ok = got && (v === 32'h00000000);
        end
    endtask
endmodule

// File: testbench/tb_pie_invert_engine.sv
// self-checking bench of the image inversion engine
`timescale 1ns/1ps
module tb_pie_invert_engine import pie_pkg::*;;
    // ======================================
    // small frame: 8x8 pixels, 4 bytes each, 64 words, so walks stay short
    localparam int WORDS = 8 * 8 * 4 / 4;
    localparam logic [15:0] MAKER = 16'h3C5A; // arbitrary value
    localparam logic [15:0] PART = 16'h0A61; // arbitrary value
    localparam logic [31:0] BUSY1 = 32'h00000001 << CSR_BUSY_POS;
    typedef struct packed {
        pie_dma_wr_t wr; // word written
        logic [DATA_W-1:0] inv; // word expected after one inversion
    } pie_row_t;
    // first, second and the two last words of the frame
    localparam pie_row_t ROWS [4] = '{
        {18'h00000, 32'h00000000, 32'hFFFFFFFF}, {18'h00004, 32'h12345678, 32'hEDCBA987},
        {18'h000F8, 32'hA5A5C3C3, 32'h5A5A3C3C}, {18'h000FC, 32'hFFFFFFFF, 32'h00000000}};
    logic core_clk, rst_b, csrWrite, csrRead, csrRdValid, dmaWrValid, dmaWrReady;
    logic dmaRdReq, dmaRdValid, engineBusy, ok;
    logic [CSR_ADDR_W-1:0] csrAddr;
    logic [DATA_W-1:0] csrWdata, csrRdData, dmaWrData, dmaRdData, d;
    logic [ADDR_W-1:0] dmaWrAddr, dmaRdAddr;
    logic [15:0] makerIdCode, partIdCode;
    int miscompares = 0, checkCount = 0, cyc = 0, t0;
    // ======================================
    // clock, cycle count and watchdog
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc++;
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        giveVerdict();
    end
    pie_invert_engine #(.WIDTH_PX(8), .HEIGHT_LINES(8), .BYTES_PX(4), .FIFO_DEPTH(16),
        .MAKER_ID_CODE(MAKER), .PART_ID_CODE(PART)) uut (.core_clk(core_clk), .rst_b(rst_b),
        .csrWrite(csrWrite), .csrRead(csrRead), .csrAddr(csrAddr), .csrWdata(csrWdata),
        .csrRdValid(csrRdValid), .csrRdData(csrRdData), .dmaWrValid(dmaWrValid),
        .dmaWrReady(dmaWrReady), .dmaWrAddr(dmaWrAddr), .dmaWrData(dmaWrData),
        .dmaRdReq(dmaRdReq), .dmaRdAddr(dmaRdAddr), .dmaRdValid(dmaRdValid),
        .dmaRdData(dmaRdData), .makerIdCode(makerIdCode), .partIdCode(partIdCode),
        .engineBusy(engineBusy));
    pie_host_model host (.core_clk(core_clk), .csrWrite(csrWrite), .csrRead(csrRead),
        .csrAddr(csrAddr), .csrWdata(csrWdata), .csrRdValid(csrRdValid),
        .csrRdData(csrRdData), .dmaWrValid(dmaWrValid), .dmaWrReady(dmaWrReady),
        .dmaWrAddr(dmaWrAddr), .dmaWrData(dmaWrData), .dmaRdReq(dmaRdReq),
        .dmaRdAddr(dmaRdAddr), .dmaRdValid(dmaRdValid), .dmaRdData(dmaRdData));
    // ======================================
    // shared compare and closing report
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic giveVerdict();
        if (miscompares == 0 && checkCount > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // start a walk, note the cycle, and wait by polling; a hang ends the run
    task automatic startWalk(input logic [31:0] v);
        host.csrWr(CSR_OFS, v);
        t0 = cyc;
    endtask
    task automatic waitWalk();
        host.pollIdle(ok);
        check("poll", 32'(ok), 32'h1);
        if (!ok) giveVerdict();
        check("walk len", 32'(cyc - t0 >= WORDS && cyc - t0 <= WORDS + 12), 32'h1);
    endtask
    // read a word over dma and compare
    task automatic rdWord(input logic [17:0] a, input logic [31:0] exp);
        host.dmaRd(a, d, ok);
        check("dma answer", 32'(ok), 32'h1);
        check("dma word", d, exp);
    endtask
    // read a register; a missing answer must not pass as a zero read
    task automatic rdCsr(input string nm, input logic [7:0] a, input logic [31:0] exp);
        host.csrRd(a, d, ok);
        check("csr answer", 32'(ok), 32'h1);
        check(nm, d, exp);
    endtask
    // ======================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk) #1;
        // values after reset, identity straps
        check("busy", 32'(engineBusy), 32'h0);
        check("ready", 32'(dmaWrReady), 32'h1);
        check("maker", 32'(makerIdCode), 32'(MAKER));
        check("part", 32'(partIdCode), 32'(PART));
        rdCsr("status", CSR_OFS, 32'h0);
        // whole frame first, so the walk never meets an unknown word
        for (int k = 0; k < WORDS; k++) host.dmaWr(18'(k * 4), 32'h5A000000 | k, 4, ok);
        // row table: load from base zero, read back, invert, read result
        foreach (ROWS[i]) host.dmaWr(ROWS[i].wr.addr, ROWS[i].wr.data, 4, ok);
        foreach (ROWS[i]) rdWord(ROWS[i].wr.addr, ROWS[i].wr.data);
        startWalk(32'h00000000); // zero data still starts
        rdCsr("status busy", CSR_OFS, BUSY1);
        waitWalk();
        foreach (ROWS[i]) rdWord(ROWS[i].wr.addr, ROWS[i].inv);
        // fill the write buffer during a walk, restart attempt must be ignored
        startWalk(32'hFFFFFFFF);
        for (int k = 0; k < 16; k++) begin
            host.dmaWr(18'((16 + k) * 4), 32'hC0DE0000 | k, 2, ok);
            check("fifo take", 32'(ok), 32'h1);
        end
        host.dmaWr(18'h00080, 32'h0BAD0BAD, 3, ok);
        check("fifo full", 32'(ok), 32'h0);
        check("ready low", 32'(dmaWrReady), 32'h0);
        host.csrWr(CSR_OFS, 32'h00000001);
        waitWalk();
        repeat (20) @(posedge core_clk); // drain of 16 words, one per cycle
        foreach (ROWS[i]) rdWord(ROWS[i].wr.addr, ROWS[i].wr.data);
        for (int k = 0; k < 16; k++) rdWord(18'((16 + k) * 4), 32'hC0DE0000 | k);
        // the refused word must not land; two walks restore the fill value
        rdWord(18'h00080, 32'h5A000020);
        // other offsets and addresses past the frame
        host.csrWr(8'h14, 32'h00000001);
        @(posedge core_clk) #1;
        check("no start", 32'(engineBusy), 32'h0);
        rdCsr("unmapped", 8'h14, 32'h0);
        rdWord(18'h00100, 32'h0);
        // reset in mid-walk
        startWalk(32'h00000005);
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b0;
        @(posedge core_clk) #1;
        check("reset busy", 32'(engineBusy), 32'h0);
        @(posedge core_clk);
        rst_b <= 1'b1;
        rdCsr("reset status", CSR_OFS, 32'h0);
        giveVerdict();
    end
endmodule
